// ==== logic/slq_pkg.sv ====
`default_nettype none
package slq_pkg;

  // ************************************************************
  // byte layout of the query parameter
  // ************************************************************
  localparam int SLQ_BYTE_W = 8;
  localparam logic [7:0] SLQ_OFS_ID = 8'h00;
  localparam logic [7:0] SLQ_OFS_LEN = 8'h01;
  localparam logic [7:0] SLQ_OFS_ROWS = 8'h02;
  localparam logic [7:0] SLQ_OFS_ROWLEN = 8'h03;
  localparam logic [7:0] SLQ_OFS_HDR = 8'h04;

  // fixed header values
  localparam logic [7:0] SLQ_PARAM_ID = 8'h90;
  localparam logic [7:0] SLQ_PARAM_LEN = 8'h56;
  localparam logic [7:0] SLQ_NUM_ROWS = 8'h06;
  localparam logic [7:0] SLQ_ROW_LEN = 8'h0e;
  localparam logic [7:0] SLQ_ASCII_F = 8'h46;
  localparam logic [7:0] SLQ_ASCII_C = 8'h43;
  // last valid offset follows from the length byte
  localparam logic [7:0] SLQ_TBL_LAST = SLQ_OFS_LEN + SLQ_PARAM_LEN;
  // cycle count meaning "not supported in this band"
  localparam logic [7:0] SLQ_NA = 8'hff;
  // filler for offsets beyond the parameter
  localparam logic [7:0] SLQ_OOR_DATA = 8'h00;
  // pointer value so that the first advance lands on offset zero
  localparam logic [7:0] SLQ_PTR_RST = 8'hff;

  // ************************************************************
  // commands and opcodes, column order of the table
  // ************************************************************
  localparam int SLQ_NUM_CMDS = 6;
  localparam int SLQ_NUM_OPC = 2 * SLQ_NUM_CMDS;
  localparam logic [7:0] SLQ_OPC [0:SLQ_NUM_OPC-1] = '{
    8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
    8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};

  typedef enum logic [2:0] {
    SLQ_CMD_READ, SLQ_CMD_FAST, SLQ_CMD_DUAL_OUT,
    SLQ_CMD_QUAD_OUT, SLQ_CMD_DUAL_IO, SLQ_CMD_QUAD_IO
  } slq_cmd_e;

  // ************************************************************
  // data rows: freq, code, then mode/latency pairs per command
  // ************************************************************
  localparam int SLQ_DATA_ROWS = 5;
  localparam int SLQ_COL_FREQ = 0;
  localparam int SLQ_COL_CODE = 1;
  localparam int SLQ_COL_PAIR0 = 2;
  typedef logic [0:13][7:0] slq_row_t;
  localparam slq_row_t SLQ_ROWS [0:SLQ_DATA_ROWS-1] = '{
    {8'h32, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
     8'h00, 8'h00, 8'h04, 8'h00, 8'h02, 8'h01},
    {8'h50, 8'h00, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08,
     8'h00, 8'h08, 8'h04, 8'h00, 8'h02, 8'h04},
    {8'h5a, 8'h01, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08,
     8'h00, 8'h08, 8'h04, 8'h01, 8'h02, 8'h04},
    {8'h68, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'h00, 8'h08,
     8'h00, 8'h08, 8'h04, 8'h02, 8'h02, 8'h05},
    {8'h85, 8'h02, 8'hff, 8'hff, 8'h00, 8'h08, 8'hff, 8'hff,
     8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff}};

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic start;
    logic next;
    logic [7:0] addr;
  } slq_qry_req_s;

  typedef struct packed {
    logic vld;
    logic [7:0] data;
    logic last;
    logic oor;
  } slq_qry_rsp_s;

  typedef struct packed {
    logic vld;
    logic [7:0] opcode;
    logic [1:0] lat_code;
  } slq_cmd_req_s;

  typedef struct packed {
    logic vld;
    logic known;
    logic four_byte;
    logic supported;
    slq_cmd_e cmd;
    logic [7:0] mode;
    logic [7:0] lat;
    logic [8:0] wait_cycles;
  } slq_cmd_rsp_s;

endpackage : slq_pkg
`default_nettype wire

// ==== logic/slq_rom.sv ====
`timescale 1ns/1ps
`default_nettype none
module slq_rom (
  // byte offset within the parameter
  input wire logic [7:0] addr,
  // byte at that offset
  output logic [7:0] data,
  output logic oor
);
  import slq_pkg::*;

  logic [7:0] rel;
  logic [7:0] row;
  logic [7:0] col;

  // ************************************************************
  // combinational table read
  // ************************************************************
  // rows are computed, not stored flat, so each figure sits once in the package
  always_comb begin
    rel = addr - SLQ_OFS_HDR;
    row = rel / SLQ_ROW_LEN;
    col = rel % SLQ_ROW_LEN;
    data = SLQ_OOR_DATA;
    oor = 1'b0;
    if (addr > SLQ_TBL_LAST) begin
      oor = 1'b1;
    end else if (addr == SLQ_OFS_ID) begin
      data = SLQ_PARAM_ID; // see [R1]
    end else if (addr == SLQ_OFS_LEN) begin
      data = SLQ_PARAM_LEN; // see [R2]
    end else if (addr == SLQ_OFS_ROWS) begin
      data = SLQ_NUM_ROWS; // see [R2]
    end else if (addr == SLQ_OFS_ROWLEN) begin
      data = SLQ_ROW_LEN; // see [R2]
    end else if (row == 8'h00) begin
      // header row: column titles then opcode labels
      if (col == 8'h00) begin
        data = SLQ_ASCII_F; // see [R3]
      end else if (col == 8'h01) begin
        data = SLQ_ASCII_C; // see [R3]
      end else begin
        data = SLQ_OPC[4'(col - 8'h02)]; // see [R3]
      end
    end else begin
      data = SLQ_ROWS[3'(row - 8'h01)][4'(col)]; // see [R10] [R13] [R14] [R18] [R19] [R20]
    end
  end

endmodule : slq_rom
`default_nettype wire

// ==== logic/slq_table.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] byte zero of the parameter reads as its identifier, 90h
// [R2] byte one holds following-byte count 56h; six rows of fourteen bytes
// [R3] header row: ASCII F, ASCII C, then the twelve read opcodes
// [R4] plain read decodes as 03h (3-byte) and 13h (4-byte)
// [R5] fast read decodes as 0Bh and 0Ch
// [R6] dual-output read decodes as 3Bh and 3Ch
// [R7] quad-output read decodes as 6Bh and 6Ch
// [R8] dual I/O read decodes as BBh and BCh
// [R9] quad I/O read decodes as EBh and ECh
// [R10] rows open with frequency limit then code; row two is 50 MHz, 11b
// [R11] code 11b: plain, fast, dual-out, quad-out use no mode, no latency
// [R12] code 11b: dual I/O four mode; quad I/O two mode, one latency
// [R13] row three allows 80 MHz with code 00b
// [R14] FFh counts mean unsupported; plain read unsupported at 80 MHz
// [R15] code 00b: fast and output reads zero mode, eight latency
// [R16] code 00b: dual I/O four mode, zero latency
// [R17] code 00b: quad I/O two mode, four latency
// [R18] row four: 90 MHz, 01b; dual I/O four mode one latency
// [R19] row five: 104 MHz, 10b; dual I/O two, quad I/O five latency
// [R20] row six: 133 MHz, 10b; only fast read, eight latency
// [R21] cycle counts come from the row matching the configured latency code
// [R22] host picks a code fast enough and waits the listed cycles
module slq_table (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // query space byte reads
  input wire slq_pkg::slq_qry_req_s qry_req,
  output slq_pkg::slq_qry_rsp_s qry_rsp,
  // read command lookup
  input wire slq_pkg::slq_cmd_req_s cmd_req,
  output slq_pkg::slq_cmd_rsp_s cmd_rsp,
  // inserted-cycle timing
  output logic dummy_busy,
  output logic data_go
);
  import slq_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  // the rom and the pair indexing assume this exact geometry
  if (SLQ_NUM_OPC != 12 || SLQ_DATA_ROWS != 5) begin : g_geom_chk
    $error("slq_table: table geometry does not match the decoder");
  end

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [7:0] qptr;
    slq_qry_rsp_s qry;
    slq_cmd_rsp_s cmd;
    logic [8:0] cnt;
    logic busy;
    logic go;
  } slq_state_s;

  slq_state_s st_ff;
  slq_state_s nxt_st;

  // ************************************************************
  // query byte path
  // ************************************************************
  logic [7:0] q_addr;
  logic [7:0] q_data;
  logic q_oor;

  // start jumps to an offset, next walks on from the last byte returned;
  // start wins when both are raised so a host can always resynchronise
  always_comb begin
    if (qry_req.start) begin
      q_addr = qry_req.addr;
    end else begin
      q_addr = st_ff.qptr + 8'h01;
    end
  end

  slq_rom u_rom (
    .addr(q_addr),
    .data(q_data),
    .oor(q_oor)
  );

  // ************************************************************
  // opcode decode
  // ************************************************************
  logic [SLQ_NUM_OPC-1:0] opc_hit;
  logic [SLQ_DATA_ROWS-1:0] row_hit;

  // one comparator per opcode; even entries are 3-byte, odd are 4-byte
  for (genvar gi = 0; gi < SLQ_NUM_OPC; gi++) begin : g_opc
    assign opc_hit[gi] = (cmd_req.opcode == SLQ_OPC[gi]); // see [R4] [R5] [R6] [R7] [R8] [R9]
  end

  // one comparator per data row on its latency code byte
  for (genvar gr = 0; gr < SLQ_DATA_ROWS; gr++) begin : g_row
    assign row_hit[gr] = (SLQ_ROWS[gr][SLQ_COL_CODE][1:0] == cmd_req.lat_code); // see [R21]
  end

  logic dec_known;
  logic dec_four;
  logic [2:0] dec_idx;

  // priority encode the opcode hit; at most one can be set
  always_comb begin
    dec_known = 1'b0;
    dec_four = 1'b0;
    dec_idx = 3'h0;
    for (int i = 0; i < SLQ_NUM_OPC; i++) begin
      if (opc_hit[i] && !dec_known) begin
        dec_known = 1'b1;
        dec_four = 1'(i % 2);
        dec_idx = 3'(i / 2);
      end
    end
  end

  // ************************************************************
  // row select and cycle lookup
  // ************************************************************
  logic row_found;
  logic [2:0] row_sel;
  logic [7:0] lk_mode;
  logic [7:0] lk_lat;
  logic lk_ok;

  // code 10b labels two rows; the lower band is taken since it lists
  // five of the six commands, the upper only fast read; limitation noted for the host
  always_comb begin
    row_found = 1'b0;
    row_sel = 3'h0;
    for (int r = 0; r < SLQ_DATA_ROWS; r++) begin
      if (row_hit[r] && !row_found) begin
        row_found = 1'b1;
        row_sel = 3'(r);
      end
    end
  end

  // pair index 2k is mode cycles, 2k+1 latency cycles for command k
  always_comb begin
    lk_mode = SLQ_ROWS[row_sel][4'(SLQ_COL_PAIR0) + 4'({dec_idx, 1'b0})]; // see [R11] [R12]
    lk_lat = SLQ_ROWS[row_sel][4'(SLQ_COL_PAIR0) + 4'({dec_idx, 1'b1})]; // see [R15] [R16] [R17]
    // all ones in either byte marks the command unsupported
    lk_ok = dec_known && row_found && (lk_mode != SLQ_NA) && (lk_lat != SLQ_NA); // see [R14]
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    nxt_st = st_ff;
    nxt_st.qry.vld = 1'b0;
    nxt_st.cmd.vld = 1'b0;
    nxt_st.go = 1'b0;

    // query byte returned one cycle after the request
    if (qry_req.start || qry_req.next) begin
      nxt_st.qptr = q_addr;
      nxt_st.qry.vld = 1'b1;
      nxt_st.qry.data = q_data; // see [R1] [R2] [R3]
      nxt_st.qry.oor = q_oor;
      nxt_st.qry.last = (q_addr == SLQ_TBL_LAST); // see [R2]
    end

    // countdown of inserted cycles; ends with a single go pulse
    if (st_ff.busy) begin
      nxt_st.cnt = st_ff.cnt - 9'h001;
      if (st_ff.cnt == 9'h001) begin
        nxt_st.busy = 1'b0;
        nxt_st.go = 1'b1;
      end
    end

    // lookup answered one cycle after the request; a new command
    // restarts the countdown rather than queueing behind the old one
    if (cmd_req.vld) begin
      nxt_st.cmd.vld = 1'b1;
      nxt_st.cmd.known = dec_known;
      nxt_st.cmd.four_byte = dec_four;
      nxt_st.cmd.supported = lk_ok; // see [R14]
      nxt_st.cmd.cmd = slq_cmd_e'(dec_idx);
      nxt_st.cmd.mode = dec_known ? lk_mode : SLQ_NA;
      nxt_st.cmd.lat = dec_known ? lk_lat : SLQ_NA;
      nxt_st.cmd.wait_cycles = {1'b0, lk_mode} + {1'b0, lk_lat}; // see [R22]
      nxt_st.busy = 1'b0;
      nxt_st.cnt = 9'h000;
      if (lk_ok) begin
        if (({1'b0, lk_mode} + {1'b0, lk_lat}) == 9'h000) begin
          nxt_st.go = 1'b1; // see [R11]
        end else begin
          nxt_st.busy = 1'b1;
          nxt_st.cnt = {1'b0, lk_mode} + {1'b0, lk_lat}; // see [R12] [R15]
        end
      end else begin
        nxt_st.go = 1'b0;
        nxt_st.cmd.wait_cycles = 9'h000;
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.qptr <= SLQ_PTR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // outputs straight from the state register
  // ************************************************************
  assign qry_rsp = st_ff.qry;
  assign cmd_rsp = st_ff.cmd;
  assign dummy_busy = st_ff.busy;
  assign data_go = st_ff.go;

endmodule : slq_table
`default_nettype wire

// ==== verification/slq_table_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module slq_table_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // query port
  input wire slq_pkg::slq_qry_req_s qry_req,
  input wire slq_pkg::slq_qry_rsp_s qry_rsp,
  // lookup port
  input wire slq_pkg::slq_cmd_req_s cmd_req,
  input wire slq_pkg::slq_cmd_rsp_s cmd_rsp,
  input wire logic dummy_busy,
  input wire logic data_go
);
  import slq_pkg::*;
  // ******
  // checks
  // ******
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  property p_qry_lat;
    (qry_req.start || qry_req.next) |=> qry_rsp.vld;
  endproperty
  a_qry_lat: assert property (p_qry_lat) else $error("query answer missing");
  property p_id;
    (qry_req.start && qry_req.addr == 8'h00) |=> (qry_rsp.data == 8'h90);
  endproperty
  a_id: assert property (p_id) else $error("identifier byte wrong");
  property p_len;
    (qry_req.start && qry_req.addr == 8'h01) |=> (qry_rsp.data == 8'h56);
  endproperty
  a_len: assert property (p_len) else $error("length byte wrong");
  property p_last;
    (qry_req.start && qry_req.addr == 8'h57) |=> (qry_rsp.last && !qry_rsp.oor);
  endproperty
  a_last: assert property (p_last) else $error("last byte not flagged");
  property p_oor;
    (qry_req.start && qry_req.addr > 8'h57) |=> (qry_rsp.oor && qry_rsp.data == 8'h00);
  endproperty
  a_oor: assert property (p_oor) else $error("byte beyond table wrong");
  property p_cmd_lat;
    cmd_req.vld |=> cmd_rsp.vld;
  endproperty
  a_cmd_lat: assert property (p_cmd_lat) else $error("lookup answer missing");
  property p_zero_go;
    (cmd_rsp.vld && cmd_rsp.supported && cmd_rsp.wait_cycles == 9'h000)
      |-> (data_go && !dummy_busy);
  endproperty
  a_zero_go: assert property (p_zero_go) else $error("no-wait read not started");
  property p_qio;
    (cmd_req.vld && cmd_req.opcode == 8'heb && cmd_req.lat_code == 2'b00)
      ##1 (!cmd_req.vld) [*6] |-> dummy_busy ##1 (!dummy_busy && data_go);
  endproperty
  a_qio: assert property (p_qio) else $error("quad io countdown wrong");
  property p_unsup;
    (cmd_rsp.vld && !cmd_rsp.supported) |-> !data_go;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported read started");
  property p_wait;
    (cmd_rsp.vld && cmd_rsp.supported) |-> (cmd_rsp.wait_cycles == cmd_rsp.mode + cmd_rsp.lat);
  endproperty
  a_wait: assert property (p_wait) else $error("wait is not mode plus latency");
  c_oor: cover property (qry_rsp.vld && qry_rsp.oor);
  c_unsup: cover property (cmd_rsp.vld && !cmd_rsp.supported);
  c_go: cover property ($fell(dummy_busy) && data_go);
endmodule : slq_table_monitor
`default_nettype wire

// ==== verification/slq_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module slq_host_model (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // walk request from the bench
  input wire logic go,
  input wire logic [7:0] base,
  input wire logic [7:0] count,
  // query requests toward the table
  output slq_pkg::slq_qry_req_s qry_req,
  output logic busy
);
  import slq_pkg::*;
  logic [7:0] left_ff;
  // ***********
  // query walker
  // ***********
  // unused offset toggles so a stale value never looks valid
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      qry_req <= '0;
      left_ff <= 8'h00;
    end else if (left_ff != 8'h00) begin
      qry_req.start <= 1'b0;
      qry_req.next <= 1'b1;
      qry_req.addr <= ~qry_req.addr;
      left_ff <= left_ff - 8'h01;
    end else if (go) begin
      qry_req <= {1'b1, 1'b0, base};
      left_ff <= count - 8'h01;
    end else begin
      qry_req.start <= 1'b0;
      qry_req.next <= 1'b0;
      qry_req.addr <= ~qry_req.addr;
    end
  end
  assign busy = left_ff != 8'h00;
endmodule : slq_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, act, exp); end end
module tb_top;
  import slq_pkg::*;
  logic mclk;
  logic sys_rst;
  slq_qry_req_s qry_req;
  slq_qry_rsp_s qry_rsp;
  slq_cmd_req_s cmd_req;
  slq_cmd_rsp_s cmd_rsp;
  logic dummy_busy;
  logic data_go;
  logic go;
  logic busy;
  logic [7:0] base;
  logic [7:0] count;
  logic [9:0] qe;
  logic [30:0] ce;
  int errors = 0;
  int num_checks = 0;
  // cycles until data may start for the last lookup, -1 when idle
  int go_rem = -1;
  logic [30:0] ca;
  int seed = 32'hff0e;
  logic [9:0] q_exp[$];
  logic [30:0] c_exp[$];
  localparam logic [0:87][7:0] TBL = {144'h9056060e464303130b0c3b3c6b6cbbbcebec,
    112'h3203000000000000000004000201, 112'h5000ffff00080008000804000204,
    112'h5a01ffff00080008000804010204, 112'h6802ffff00080008000804020205,
    112'h8502ffff0008ffffffffffffffff};
  // ********
  // harness
  // ********
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  slq_table dut (.mclk(mclk), .sys_rst(sys_rst), .qry_req(qry_req), .qry_rsp(qry_rsp),
    .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .dummy_busy(dummy_busy), .data_go(data_go));
  slq_host_model host (.mclk(mclk), .sys_rst(sys_rst), .go(go), .base(base),
    .count(count), .qry_req(qry_req), .busy(busy));
  // expected {last, oor, data}; bytes past the table read zero
  function automatic logic [9:0] q_of(input logic [7:0] a);
    q_of = (a > 8'h57) ? 10'h100 : {a == 8'h57, 1'b0, TBL[a]};
  endfunction
  task automatic walk(input logic [7:0] b, input logic [7:0] n);
    int k;
    for (k = 0; k < n; k++) q_exp.push_back(q_of(8'(b + k)));
    base <= b;
    count <= n;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (k = 0; k < 300 && busy; k++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask : walk
  // row from latency code, first match wins for the shared code
  task automatic cmd(input logic [7:0] op, input logic [1:0] code);
    int i;
    int o;
    logic [7:0] m;
    logic [7:0] l;
    logic s;
    i = 12;
    for (int j = 0; j < 12; j++) if (TBL[6 + j] == op) i = j;
    o = 20 + ((code == 2'b11) ? 0 : code + 1) * 14 + (i / 2) * 2;
    m = (i < 12) ? TBL[o] : 8'hff;
    l = (i < 12) ? TBL[o + 1] : 8'hff;
    s = (i < 12) && m != 8'hff && l != 8'hff;
    c_exp.push_back({i < 12, i < 12 && i[0], s, 3'((i < 12) ? i / 2 : 0), m, l,
      s ? ({1'b0, m} + {1'b0, l}) : 9'h000});
    cmd_req <= {1'b1, op, code};
    @(posedge mclk);
  endtask : cmd
  task automatic tally_and_finish();
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // result watcher pairs each answer with the oldest note
  always @(posedge mclk) begin
    if (qry_rsp.vld) begin
      `CHK(q_exp.size() > 0, 1'b1)
      qe = q_exp.pop_front();
      `CHK({qry_rsp.last, qry_rsp.oor, qry_rsp.data}, qe)
    end
    if (cmd_rsp.vld) begin
      `CHK(c_exp.size() > 0, 1'b1)
      ce = c_exp.pop_front();
      ca = {cmd_rsp.known, cmd_rsp.four_byte, cmd_rsp.supported, cmd_rsp.cmd,
        cmd_rsp.mode, cmd_rsp.lat, cmd_rsp.wait_cycles};
      `CHK(ca, ce)
      // a new answer restarts the wait, taken from the noted counts
      go_rem = ce[28] ? int'(ce[8:0]) : -1;
    end else if (go_rem >= 0) begin
      go_rem = go_rem - 1;
    end
    // busy while cycles remain, one go pulse when they run out
    if (!sys_rst) begin
      `CHK({dummy_busy, data_go}, {go_rem > 0, go_rem == 0})
    end
  end
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    tally_and_finish();
  end
  initial begin
    sys_rst = 1'b1;
    go = 1'b0;
    base = 8'h00;
    count = 8'h00;
    cmd_req = '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    walk(8'h00, 8'h5b);
    walk(8'hfe, 8'h04);
    for (int n = 0; n < 6; n++) walk(8'($random(seed)), 8'h01 + 8'({$random(seed)} % 32));
    // every opcode under every code, plus one foreign opcode
    for (int c = 0; c < 4; c++) begin
      for (int j = 0; j < 13; j++) begin
        cmd((j < 12) ? TBL[6 + j] : 8'h02, 2'(c));
        cmd_req.vld <= 1'b0;
        repeat (12) @(posedge mclk);
      end
    end
    // back-to-back lookups restart the countdown
    for (int j = 0; j < 20; j++) cmd(TBL[6 + {$random(seed)} % 12], 2'($random(seed)));
    cmd_req.vld <= 1'b0;
    repeat (15) @(posedge mclk);
    tally_and_finish();
  end
endmodule : tb_top
bind slq_table slq_table_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .qry_req(qry_req),
  .qry_rsp(qry_rsp), .cmd_req(cmd_req), .cmd_rsp(cmd_rsp), .dummy_busy(dummy_busy),
  .data_go(data_go));
`default_nettype wire
